// file: core/dsfs_top.sv
// Drive stop sequencer and frequency shaper with an APB register slave.
// Assumes APB master on mclk; bus voltage and overcurrent synchronous inputs.
module dsfs_top
  import dsfs_pkg::*;
#(
  parameter int TIME_TICK_CYC = dsfs_pkg::TIME_CYC,
  parameter int RAMP_TICK_CYC = dsfs_pkg::RAMP_CYC
) (
  input  wire logic        mclk,           // 10 MHz clock
  input  wire logic        rst_n,          // Async reset, active low
  input  wire logic        mclk_en,        // Clock enable
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic [15:0] dc_bus_volt,    // DC bus voltage sample
  input  wire logic        over_current,   // Output current above stall level
  output logic      [15:0] out_freq,       // Output frequency, 0.01 Hz
  output logic             out_enable,     // Output stage gates on
  output logic             dc_inj_active,  // DC injection applied
  output logic      [15:0] dc_inj_current  // Injection current command
);
  import dsfs_pkg::*;

  // Configuration, sequencer and bus answer all live in one registered copy
  typedef struct packed {
    logic [7:0]        ctrl;
    logic [15:0]       start_f;
    logic [15:0]       max_f;
    logic [15:0]       floor_f;
    logic [15:0]       ceil_f;
    logic [15:0]       ref_f;
    logic [5:0][15:0]  band;
    logic [15:0]       blk_t;
    logic [15:0]       inj_t;
    logic [7:0]        lvl;
    logic [15:0]       inj_f;
    logic [15:0]       step;
    logic [15:0]       bus_th;
    logic [15:0]       rated;
    dsfs_state_t       st;
    logic [15:0]       cnt;
    logic [15:0]       out_f;
    logic              gate;
    logic              inj;
    logic [15:0]       amp;
    logic              pb;
    logic              rdy;
    logic              err;
    logic              slverr;
    logic [15:0]       cur;
    logic [31:0]       rdata;
  } dsfs_top_s_t;

  dsfs_top_s_t       q, d;
  logic              ttick;
  logic              rtick;
  logic [15:0]       tgt_f;
  logic [2:0][15:0]  band_lo;
  logic [2:0][15:0]  band_hi;
  logic [23:0]       prod;

  // Out-of-range writes are pulled into range, never refused
  function automatic logic [15:0] sat(input logic [31:0] v,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
    logic [15:0] r;
    r = 16'(v);
    if (v > {16'h0000, hi}) begin
      r = hi;
    end else if (v < {16'h0000, lo}) begin
      r = lo;
    end
    return r;
  endfunction : sat

  // Band words alternate floor and ceiling in address order
  for (genvar i = 0; i < NBAND; i++) begin : g_edges
    assign band_lo[i] = q.band[2*i];
    assign band_hi[i] = q.band[2*i+1];
  end

  // Tick phases run free, so the first tick of a timed interval may come early
  dsfs_tick #(
    .DIV (TIME_TICK_CYC)
  ) u_time_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .tick    (ttick)
  );

  dsfs_tick #(
    .DIV (RAMP_TICK_CYC)
  ) u_ramp_tick (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .mclk_en (mclk_en),
    .tick    (rtick)
  );

  dsfs_shape u_shape (
    .ref_f   (q.ref_f),
    .start_f (q.start_f),
    .max_f   (q.max_f),
    .floor_f (q.floor_f),
    .ceil_f  (q.ceil_f),
    .lim_en  (q.ctrl[C_LIM]),
    .jmp_en  (q.ctrl[C_JMP]),
    .band_lo (band_lo),
    .band_hi (band_hi),
    .tgt_f   (tgt_f)
  );

  // Rated current times percent level; the divide by 100 is registered below
  assign prod = q.rated * q.lvl;

  always_comb begin
    logic        stop;
    logic [2:0]  mode;
    logic [15:0] goal;
    logic [16:0] up;
    logic        setup;
    logic        wr;
    logic [15:0] injf_hi;
    d     = q;
    stop  = ~q.ctrl[C_RUN];
    mode  = q.ctrl[C_MODE +: 3];
    goal  = stop ? 16'h0000 : tgt_f;
    up    = {1'b0, q.out_f} + {1'b0, q.step};
    setup = psel & ~penable;
    // A write lands at the access edge, while ready already stands high
    wr    = psel & penable & q.rdy & pwrite;
    // Injection start is a speed setting too, so it obeys the maximum
    injf_hi = (q.max_f < INJF_MAX) ? q.max_f : INJF_MAX;
    d.amp = 16'(prod / PCT_DIV);
    d.pb  = 1'b0;

    // Answer one cycle after setup, so the data path is registered
    d.rdy = setup & ~q.rdy;
    if (setup) begin
      d.err   = 1'b0;
      d.rdata = '0;
      unique case (paddr)
        A_CTRL:   d.rdata = {24'h000000, q.ctrl};
        A_START:  d.rdata = {16'h0000, q.start_f};
        A_MAX:    d.rdata = {16'h0000, q.max_f};
        A_FLOOR:  d.rdata = q.ctrl[C_LIM] ? {16'h0000, q.floor_f} : '0;
        A_CEIL:   d.rdata = q.ctrl[C_LIM] ? {16'h0000, q.ceil_f} : '0;
        A_REF:    d.rdata = {16'h0000, q.ref_f};
        A_BLK:    d.rdata = {16'h0000, q.blk_t};
        A_INJT:   d.rdata = {16'h0000, q.inj_t};
        A_LVL:    d.rdata = {24'h000000, q.lvl};
        A_INJF:   d.rdata = {16'h0000, q.inj_f};
        A_STEP:   d.rdata = {16'h0000, q.step};
        A_BUSTH:  d.rdata = {16'h0000, q.bus_th};
        A_RATED:  d.rdata = {16'h0000, q.rated};
        A_STATUS: d.rdata = {10'h000, q.pb, q.st, q.inj, q.gate, q.out_f};
        A_TGT:    d.rdata = {16'h0000, tgt_f};
        default: begin
          d.err = 1'b1;
          for (int i = 0; i < 6; i++) begin
            if (paddr == A_BAND0 + 8'(4 * i)) begin
              d.err   = 1'b0;
              d.rdata = {16'h0000, q.band[i]};
            end
          end
        end
      endcase
    end
    // Error registered beside ready so the output comes straight from a flop
    d.slverr = d.rdy & d.err;

    // A refused setup also blocks its access-phase write
    if (wr && !q.err) begin
      unique case (paddr)
        A_CTRL:  d.ctrl    = pwdata[7:0];
        A_START: d.start_f = sat(pwdata, START_MIN, START_MAX);
        A_MAX: begin
          d.max_f   = sat(pwdata, MAXF_MIN, MAXF_MAX);
          // A lower maximum drags every stored speed setting above it down to it, so no
          // setting reads back above the new maximum
          d.floor_f = sat({16'h0000, q.floor_f}, 16'h0000, d.max_f);
          d.ceil_f  = sat({16'h0000, q.ceil_f}, 16'h0000, d.max_f);
          d.ref_f   = sat({16'h0000, q.ref_f}, 16'h0000, d.max_f);
          d.inj_f   = sat({16'h0000, q.inj_f}, 16'h0000, d.max_f);
          // Both edges of a band meet the same cap, so floor stays at or below ceiling
          for (int i = 0; i < 6; i++) begin
            d.band[i] = sat({16'h0000, q.band[i]}, 16'h0000, d.max_f);
          end
        end
        A_FLOOR: d.floor_f = sat(pwdata, 16'h0000, q.max_f);
        A_CEIL:  d.ceil_f  = sat(pwdata, q.floor_f, q.max_f);
        A_REF:   d.ref_f   = sat(pwdata, 16'h0000, q.max_f);
        A_BLK:   d.blk_t   = sat(pwdata, 16'h0000, TIME_MAX);
        A_INJT:  d.inj_t   = sat(pwdata, 16'h0000, TIME_MAX);
        A_LVL:   d.lvl     = 8'(sat(pwdata, 16'h0000, LVL_MAX));
        A_INJF:  d.inj_f   = sat(pwdata, 16'h0000, injf_hi);
        A_STEP:  d.step    = pwdata[15:0];
        A_BUSTH: d.bus_th  = pwdata[15:0];
        A_RATED: d.rated   = pwdata[15:0];
        default: begin
          for (int i = 0; i < 3; i++) begin
            if (paddr == A_BAND0 + 8'(8 * i)) begin
              d.band[2*i] = sat(pwdata, 16'h0000, q.band[2*i+1]);
            end
            if (paddr == A_BAND0 + 8'(8 * i + 4)) begin
              d.band[2*i+1] = sat(pwdata, q.band[2*i], q.max_f);
            end
          end
        end
      endcase
    end

    // Stop sequencer: RUN ramps toward the shaped goal, stop modes leave from RUN
    unique case (q.st)
      ST_IDLE: begin
        // Output frequency starts from zero on every run
        d.gate  = 1'b0;
        d.inj   = 1'b0;
        d.out_f = '0;
        if (!stop) begin
          d.gate = 1'b1;
          d.st   = ST_RUN;
        end
      end
      ST_RUN: begin
        d.gate = 1'b1;
        if (stop && mode == SM_FREE) begin
          d.gate  = 1'b0;
          d.out_f = '0;
          d.st    = ST_IDLE;
        end else if (stop && mode == SM_DCB && q.out_f <= q.inj_f) begin
          // Dwell has no hold here: the output block always comes first, then injection
          d.gate  = 1'b0;
          d.out_f = '0;
          d.cnt   = '0;
          d.st    = ST_BLOCK;
        end else if (stop && q.out_f == 16'h0000) begin
          d.gate = 1'b0;
          d.st   = ST_IDLE;
        end else if (q.out_f < goal) begin
          if (rtick) begin
            d.out_f = (up > {1'b0, goal}) ? goal : up[15:0];
          end
        end else if (q.out_f > goal) begin
          // Power braking is tested before stall so it wins when both are enabled
          if (mode == SM_PWR && dc_bus_volt > q.bus_th) begin
            d.pb = 1'b1;
            if (rtick && q.ctrl[C_REACC]) begin
              d.out_f = (up > {1'b0, q.max_f}) ? q.max_f : up[15:0];
            end
          end else if (q.ctrl[C_STALL] && over_current) begin
            d.out_f = q.out_f;
          end else if (rtick) begin
            // Ramp walks straight through skip bands
            d.out_f = (q.out_f - goal > q.step) ? q.out_f - q.step : goal;
          end
        end
      end
      ST_BLOCK: begin
        // Block and inject share one tick counter, cleared on each entry
        d.gate = 1'b0;
        if (q.cnt >= q.blk_t) begin
          d.cnt = '0;
          d.inj = 1'b1;
          d.st  = ST_INJECT;
        end else if (ttick) begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      ST_INJECT: begin
        // A new run command waits until the injection has finished
        d.inj = 1'b1;
        if (q.cnt >= q.inj_t) begin
          d.inj = 1'b0;
          d.st  = ST_IDLE;
        end else if (ttick) begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // Current command registered with its gate so it never glitches
    d.cur = d.inj ? d.amp : 16'h0000;
  end

  // Reset loads the power-on settings; the sequencer starts idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q         <= '0;
      q.ctrl    <= RST_CTRL;
      q.start_f <= RST_START;
      q.max_f   <= RST_MAX;
      q.floor_f <= RST_FLOOR;
      q.ceil_f  <= RST_MAX;
      q.band    <= RST_BAND;
      q.blk_t   <= RST_BLK;
      q.inj_t   <= RST_INJT;
      q.lvl     <= RST_LVL;
      q.inj_f   <= RST_INJF;
      q.step    <= RST_STEP;
      q.bus_th  <= RST_BUSTH;
      q.rated   <= RST_RATED;
      q.st      <= ST_IDLE;
    end else if (mclk_en) begin
      q <= d;
    end
  end

  // Every output is a plain register copy
  assign prdata         = q.rdata;
  assign pready         = q.rdy;
  assign pslverr        = q.slverr;
  assign out_freq       = q.out_f;
  assign out_enable     = q.gate;
  assign dc_inj_active  = q.inj;
  assign dc_inj_current = q.cur;
endmodule : dsfs_top

// file: common/dsfs_pkg.sv
// Package of the drive stop and frequency shaper: map, fields, resets, timing.
// Assumes frequencies in 0.01 Hz, times in 0.01 s, a 10 MHz mclk.
package dsfs_pkg;
  localparam int          FW            = 16;
  localparam int          NBAND         = 3;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          TIME_UNIT_NS  = 10_000_000;
  localparam int          RAMP_UNIT_NS  = 1_000_000;
  localparam int          TIME_CYC      = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RAMP_CYC      = (RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0]  A_CTRL        = 8'h00;
  localparam logic [7:0]  A_START       = 8'h04;
  localparam logic [7:0]  A_MAX         = 8'h08;
  localparam logic [7:0]  A_FLOOR       = 8'h0C;
  localparam logic [7:0]  A_CEIL        = 8'h10;
  localparam logic [7:0]  A_REF         = 8'h14;
  localparam logic [7:0]  A_BAND0       = 8'h18;
  localparam logic [7:0]  A_BLK         = 8'h30;
  localparam logic [7:0]  A_INJT        = 8'h34;
  localparam logic [7:0]  A_LVL         = 8'h38;
  localparam logic [7:0]  A_INJF        = 8'h3C;
  localparam logic [7:0]  A_STEP        = 8'h40;
  localparam logic [7:0]  A_BUSTH       = 8'h44;
  localparam logic [7:0]  A_RATED       = 8'h48;
  localparam logic [7:0]  A_STATUS      = 8'h4C;
  localparam logic [7:0]  A_TGT         = 8'h50;

  localparam int          C_MODE        = 0;
  localparam int          C_LIM         = 3;
  localparam int          C_JMP         = 4;
  localparam int          C_RUN         = 5;
  localparam int          C_STALL       = 6;
  localparam int          C_REACC       = 7;

  localparam logic [2:0]  SM_DEC        = 3'h0;
  localparam logic [2:0]  SM_DCB        = 3'h1;
  localparam logic [2:0]  SM_FREE       = 3'h2;
  localparam logic [2:0]  SM_PWR        = 3'h4;

  localparam logic [15:0] START_MIN     = 16'h0001;
  localparam logic [15:0] START_MAX     = 16'h03E8;
  localparam logic [15:0] MAXF_MIN      = 16'h0FA0;
  localparam logic [15:0] MAXF_MAX      = 16'h9C40;
  localparam logic [15:0] TIME_MAX      = 16'h1770;
  localparam logic [15:0] INJF_MAX      = 16'h1770;
  localparam logic [15:0] LVL_MAX       = 16'h00C8;
  localparam logic [23:0] PCT_DIV       = 24'h000064;

  localparam logic [7:0]  RST_CTRL      = 8'h00;
  localparam logic [15:0] RST_START     = 16'h0032;
  localparam logic [15:0] RST_MAX       = 16'h1770;
  localparam logic [15:0] RST_FLOOR     = 16'h0032;
  localparam logic [15:0] RST_BLK       = 16'h000A;
  localparam logic [15:0] RST_INJT      = 16'h0064;
  localparam logic [7:0]  RST_LVL       = 8'h32;
  localparam logic [15:0] RST_INJF      = 16'h01F4;
  localparam logic [15:0] RST_STEP      = 16'h0001;
  localparam logic [15:0] RST_BUSTH     = 16'hFFFF;
  localparam logic [15:0] RST_RATED     = 16'h0000;
  localparam logic [5:0][15:0] RST_BAND = {16'h0DAC, 16'h0BB8, 16'h09C4,
                                           16'h07D0, 16'h05DC, 16'h03E8};

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_BLOCK, ST_INJECT} dsfs_state_t;
endpackage : dsfs_pkg

// file: core/dsfs_tick.sv
// Free-running divider giving a one-cycle tick every DIV enabled cycles.
// Assumes the caller gates with the common clock enable.
module dsfs_tick #(
  parameter int DIV = 10
) (
  input  wire logic mclk,    // Clock
  input  wire logic rst_n,   // Async reset
  input  wire logic mclk_en, // Clock enable
  output logic      tick     // One-cycle pulse
);
  import dsfs_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic        tick;
  } dsfs_tick_s_t;
  dsfs_tick_s_t q, d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt >= 32'(DIV - 1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h00000001;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (mclk_en) begin
      q <= d;
    end
  end

  assign tick = q.tick & mclk_en;
endmodule : dsfs_tick

// file: core/dsfs_shape.sv
// Combinational shaping of the frequency reference into a ramp target.
// Assumes settings already saturated to their legal ranges on write.
module dsfs_shape (
  input  wire logic [15:0]       ref_f,   // Requested frequency
  input  wire logic [15:0]       start_f, // Start frequency
  input  wire logic [15:0]       max_f,   // Maximum frequency
  input  wire logic [15:0]       floor_f, // clamp_floor
  input  wire logic [15:0]       ceil_f,  // clamp_ceiling
  input  wire logic              lim_en,  // Clamp enable
  input  wire logic              jmp_en,  // Skip band enable
  input  wire logic [2:0][15:0]  band_lo, // Skip band floors
  input  wire logic [2:0][15:0]  band_hi, // Skip band ceilings
  output logic      [15:0]       tgt_f    // Shaped target
);
  import dsfs_pkg::*;
  logic [15:0]            f;
  logic [NBAND:0][15:0]   stage;

  always_comb begin
    f = ref_f;
    if (f < start_f) begin
      f = '0;
    end
    if (lim_en) begin
      if (f < floor_f) begin
        f = floor_f;
      end
      if (f > ceil_f) begin
        f = ceil_f;
      end
    end
    if (f > max_f) begin
      f = max_f;
    end
  end

  assign stage[0] = f;
  // A target inside a band is held at that band's floor, the bands tested once each in index order
  for (genvar i = 0; i < NBAND; i++) begin : g_band
    assign stage[i+1] = (jmp_en && stage[i] >= band_lo[i] && stage[i] <= band_hi[i])
                        ? band_lo[i] : stage[i];
  end
  assign tgt_f = stage[NBAND];
endmodule : dsfs_shape

// file: testbench/dsfs_props.sv
// Port checker of the drive stop sequencer and frequency shaper.
// Assumes it is bound into dsfs_top and that mclk_en stays high during bus transfers.
module dsfs_props
  import dsfs_pkg::*;
#(
  parameter int TIME_TICK_CYC = 10,
  parameter int RAMP_TICK_CYC = 4
) (
  input wire logic        mclk,          // Clock
  input wire logic        rst_n,         // Reset
  input wire logic        mclk_en,       // Enable
  input wire logic        psel,          // APB
  input wire logic        penable,       // APB
  input wire logic        pwrite,        // APB
  input wire logic [7:0]  paddr,         // APB
  input wire logic [31:0] pwdata,        // APB
  input wire logic [31:0] prdata,        // APB
  input wire logic        pready,        // APB
  input wire logic        pslverr,       // APB
  input wire logic [15:0] dc_bus_volt,   // Bus
  input wire logic        over_current,  // Stall
  input wire logic [15:0] out_freq,      // Frequency
  input wire logic        out_enable,    // Gates
  input wire logic        dc_inj_active, // Injection
  input wire logic [15:0] dc_inj_current // Current
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_free_stop;
    psel && penable && pready && pwrite && paddr == A_CTRL
      && !pwdata[C_RUN] && pwdata[2:0] == SM_FREE;
  endsequence
  sequence s_off;
    !out_enable && out_freq == 16'h0000;
  endsequence
  AST_APB_WAIT: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held");
  AST_ERR_QUAL: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access");
  AST_ERR_ZERO: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  AST_FREE_STOP: assert property (s_free_stop |-> ##[1:3] s_off)
    else $error("free run stop late");
  AST_BLOCK_FIRST: assert property ($rose(dc_inj_active) |-> $past(out_enable) == 1'b0)
    else $error("injection without output block");
  AST_INJ_DONE: assert property ($fell(dc_inj_active) |-> !out_enable)
    else $error("output on at end of injection");
  AST_INJ_ZERO: assert property (!dc_inj_active |-> dc_inj_current == 16'h0000)
    else $error("current without injection");
  // Ramp ticks are at least two cycles apart, so two steps in a row are a fault
  AST_RAMP_TICK: assert property (out_enable && $changed(out_freq) |=>
    !out_enable || $stable(out_freq)) else $error("frequency stepped twice");
endmodule : dsfs_props

bind dsfs_top dsfs_props #(.TIME_TICK_CYC(TIME_TICK_CYC), .RAMP_TICK_CYC(RAMP_TICK_CYC))
  u_dsfs_props (.mclk(mclk), .rst_n(rst_n), .mclk_en(mclk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .dc_bus_volt(dc_bus_volt),
  .over_current(over_current), .out_freq(out_freq), .out_enable(out_enable),
  .dc_inj_active(dc_inj_active), .dc_inj_current(dc_inj_current));

// file: testbench/dsfs_motor_model.sv
// Output stage and motor model: DC bus level and current sense.
// Assumes the bench commands regeneration and heavy load.
module dsfs_motor_model (
  input  wire logic        mclk,        // Clock
  input  wire logic        rst_n,       // Reset, active low
  input  wire logic        out_enable,  // Gates on
  input  wire logic        regen,       // Overhauling load
  input  wire logic        stall_req,   // Heavy load
  output logic      [15:0] dc_bus_volt, // Bus sample
  output logic             over_current // Above stall level
);
  timeunit 1ns;
  timeprecision 100ps;
  // A blocked stage returns no energy and draws no current
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dc_bus_volt  <= 16'h012C;
      over_current <= 1'b0;
    end else begin
      dc_bus_volt  <= (regen && out_enable) ? 16'h0258 : 16'h012C;
      over_current <= stall_req && out_enable;
    end
  end
endmodule : dsfs_motor_model

// file: testbench/tb_top.sv
// Self-checking bench of the drive stop sequencer and frequency shaper.
// Assumes short tick parameters; holds the APB master and the motor model.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import dsfs_pkg::*;
  localparam int TT = 10;
  localparam int RT = 4;
  localparam logic [10:0][7:0]  RA = {A_CTRL, A_START, A_MAX, A_FLOOR, A_CEIL, A_BLK,
                                      A_INJT, A_LVL, A_INJF, A_BAND0, 8'h2C};
  localparam logic [10:0][15:0] RE = {16'h0000, 16'h0032, 16'h1770, 16'h0000, 16'h0000,
    16'h000A, 16'h0064, 16'h0032, 16'h01F4, 16'h03E8, 16'h0DAC};
  localparam logic [4:0][7:0]   SA = {A_START, A_START, A_BAND0, 8'h1C, A_MAX};
  localparam logic [4:0][15:0]  SW = {16'h0000, 16'h07D0, 16'h2328, 16'h9C40, 16'h0064};
  localparam logic [4:0][15:0]  SE = {16'h0001, 16'h03E8, 16'h05DC, 16'h1770, 16'h0FA0};
  localparam logic [4:0][15:0]  SR = {16'h0032, 16'h0032, 16'h03E8, 16'h05DC, 16'h1770};
  localparam logic [7:0][15:0]  FC = {16'h0031, 16'h0032, 16'h03E8, 16'h05DC, 16'h05DD,
    16'h1388, 16'h1389, 16'h1B58};
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic        over_current, out_enable, dc_inj_active, regen, stall_req, clk_en;
  logic [1:0]  c;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] dc_bus_volt, out_freq, dc_inj_current, last_f, f;
  int          n, err_total, cmp_count;

  dsfs_top #(.TIME_TICK_CYC(TT), .RAMP_TICK_CYC(RT)) u_dsfs_top (
    .mclk(mclk), .rst_n(rst_n), .mclk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dc_bus_volt(dc_bus_volt), .over_current(over_current),
    .out_freq(out_freq), .out_enable(out_enable), .dc_inj_active(dc_inj_active),
    .dc_inj_current(dc_inj_current));
  dsfs_motor_model u_dsfs_motor_model (.mclk(mclk), .rst_n(rst_n),
    .out_enable(out_enable), .regen(regen), .stall_req(stall_req),
    .dc_bus_volt(dc_bus_volt), .over_current(over_current));

  always #50 mclk = ~mclk;
  // Last frequency shown while the gates were still on
  always @(posedge mclk) if (out_enable) last_f <= out_freq;

  task give_verdict;
    $display("Compares %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task tmo;
    chk(32'h0, 32'h1);
    give_verdict();
  endtask : tmo
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // k selects the watched output: 0 frequency, 1 injection, 2 gates
  task wt(input int k, input logic [15:0] v);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((k == 0 ? out_freq : k == 1 ? dc_inj_active : out_enable) !== v && n < 3000);
    if (n >= 3000) tmo();
  endtask : wt
  task run_to(input logic [7:0] ctl);
    apb(1'b1, A_CTRL, {24'h0, ctl | 8'h20});
    wt(0, 16'h03E8);
  endtask : run_to
  function automatic logic [15:0] exp_tgt(input logic [15:0] r, input logic lim,
                                          input logic jmp);
    logic [15:0] bl [3] = '{16'h03E8, 16'h07D0, 16'h0BB8};
    logic [15:0] bh [3] = '{16'h05DC, 16'h09C4, 16'h0DAC};
    if (r > 16'h1770) r = 16'h1770;
    if (r < 16'h0032) r = 16'h0000;
    if (lim) r = (r < 16'h0320) ? 16'h0320 : (r > 16'h1388) ? 16'h1388 : r;
    if (jmp) for (int i = 0; i < 3; i++) if (r >= bl[i] && r <= bh[i]) r = bl[i];
    return r;
  endfunction : exp_tgt

  initial begin
    mclk = 0;
    rst_n = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 8'h00;
    pwdata = 32'h0;
    regen = 0;
    stall_req = 0;
    clk_en = 1;
    err_total = 0;
    cmp_count = 0;
    void'($urandom(19));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    for (int i = 10; i >= 0; i--) begin
      apb(1'b0, RA[i], 32'h0);
      chk(rd, {16'h0000, RE[i]});
    end
    apb(1'b0, 8'h7C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    for (int i = 4; i >= 0; i--) begin
      apb(1'b1, SA[i], {16'h0000, SW[i]});
      apb(1'b0, SA[i], 32'h0);
      chk(rd, {16'h0000, SE[i]});
      apb(1'b1, SA[i], {16'h0000, SR[i]});
    end
    apb(1'b1, A_CTRL, 32'h8);
    apb(1'b0, A_CEIL, 32'h0);
    chk(rd, 32'h0FA0);
    apb(1'b1, A_FLOOR, 32'h0320);
    apb(1'b1, A_CEIL, 32'h1388);
    for (int i = 0; i < 40; i++) begin
      c = 2'($urandom_range(0, 3));
      f = (i < 8) ? FC[i] : 16'($urandom_range(0, 7000));
      apb(1'b1, A_CTRL, {27'h0, c, 3'h0});
      apb(1'b1, A_REF, {16'h0000, f});
      apb(1'b0, A_TGT, 32'h0);
      chk(rd, {16'h0000, exp_tgt(f, c[0], c[1])});
      apb(1'b0, A_FLOOR, 32'h0);
      chk(rd, c[0] ? 32'h0320 : 32'h0);
    end
    apb(1'b1, A_CTRL, 32'h0);
    apb(1'b1, A_REF, 32'h03E8);
    apb(1'b1, A_STEP, 32'h0032);
    apb(1'b1, A_BUSTH, 32'h01F4);
    apb(1'b1, A_RATED, 32'h03E8);
    apb(1'b1, A_LVL, 32'h0050);
    apb(1'b1, A_BLK, 32'h3);
    apb(1'b1, A_INJT, 32'h5);
    run_to(8'h02);
    apb(1'b1, A_CTRL, 32'h2);
    repeat (3) @(posedge mclk);
    chk({15'h0, out_enable, out_freq}, 32'h0);
    stall_req <= 1'b1;
    run_to(8'h40);
    apb(1'b1, A_CTRL, 32'h40);
    repeat (20) @(posedge mclk);
    chk({16'h0, out_freq}, 32'h03E8);
    stall_req <= 1'b0;
    wt(0, 16'h0000);
    repeat (3) @(posedge mclk);
    chk({30'h0, out_enable, dc_inj_active}, 32'h0);
    run_to(8'h01);
    apb(1'b1, A_CTRL, 32'h1);
    wt(2, 16'h0000);
    chk({16'h0, last_f}, 32'h01F4);
    wt(1, 16'h0001);
    chk({31'h0, n >= 2 * TT && n <= 3 * TT + 3}, 32'h1);
    chk({16'h0, dc_inj_current}, 32'h0320);
    wt(1, 16'h0000);
    chk({31'h0, n >= 4 * TT && n <= 5 * TT + 3}, 32'h1);
    chk({31'h0, out_enable}, 32'h0);
    regen <= 1'b1;
    stall_req <= 1'b1;
    run_to(8'hC4);
    repeat (12) @(posedge mclk);
    chk({16'h0, out_freq}, 32'h03E8);
    apb(1'b1, A_CTRL, 32'hC4);
    repeat (40) @(posedge mclk);
    chk({31'h0, out_freq > 16'h03E8}, 32'h1);
    apb(1'b0, A_STATUS, 32'h0);
    chk({31'h0, rd[21]}, 32'h1);
    regen <= 1'b0;
    stall_req <= 1'b0;
    // A low clock enable must freeze the ramp mid-deceleration
    repeat (8) @(posedge mclk);
    clk_en <= 1'b0;
    @(posedge mclk);
    f = out_freq;
    repeat (20) @(posedge mclk);
    chk({16'h0, out_freq}, {16'h0, f});
    clk_en <= 1'b1;
    wt(0, 16'h0000);
    give_verdict();
  end
endmodule : tb_top
